// ==== core/pcs_port_regs.vh ====
// Operation
// - Receive sync frames receive words at 8 kHz
// - Receive sync may be asynchronous to transmit
// - ISDN modes: receive sync picks B1/B2
// - Receive clock held high selects link mode A
// - Receive clock held low selects GCI mode
// - Receive clock may run 64 to 4096 kHz
// - ISDN receive uses transmit sync and clock
// - Power-down input low powers the device down
// - Both syncs low with clocks running powers down
// - Transmit output high-impedance while powered down
// - Wake needs input high plus transmit sync pulses
// - Output stays off for two syncs after wake
// - Prescaler derives 256 kHz from master clock
// - Law select changes codes, never timing
// - Mu-law zero and full-scale code points
// - A-law zero and full-scale code points
// - Mu-law digital milliwatt eight-word sequence
// - A-law digital milliwatt eight-word sequence
// - Long sync: drive when sync and clock high
// - Long sync: release at later of LSB-middle, sync-low
// - Long sync is high over two falling edges
// - Long receive: eight falls, hand over ninth rise
// - Short sync is high over one falling edge
// - Link mode A needs three sync rises
`ifndef PCS_PORT_REGS_VH
`define PCS_PORT_REGS_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define PCS_CTRL_OFS        8'h00
`define PCS_TXWORD_OFS      8'h04
`define PCS_RXWORD_OFS      8'h08
`define PCS_STATUS_OFS      8'h0C
`define PCS_PRESCALE_OFS    8'h10

// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define PCS_CTRL_SRC_LSB    0
`define PCS_CTRL_SRC_MSB    1
`define PCS_CTRL_RST        2'h0
`define PCS_TXWORD_RST      8'hFF
`define PCS_SRC_REG         2'h0
`define PCS_SRC_MW          2'h1
`define PCS_SRC_ZERO        2'h2
`define PCS_SRC_FULL        2'h3

// ------------------------------------------------------------
// Code points
// ------------------------------------------------------------
`define PCS_MU_POS_FULL     8'h80
`define PCS_MU_POS_ZERO     8'hFF
`define PCS_A_POS_FULL      8'hAA
`define PCS_A_POS_ZERO      8'hD5
`define PCS_MU_MW_OUTER     7'h1E
`define PCS_MU_MW_INNER     7'h0B
`define PCS_A_MW_OUTER      7'h34
`define PCS_A_MW_INNER      7'h21

// ------------------------------------------------------------
// Slot timing in bit clock edges; mode and guard counts in sync rises
// ------------------------------------------------------------
`define PCS_LKA_B2_OFS      6'd10
`define PCS_GCI_B2_OFS      6'd16
`define PCS_WORD_BITS       6'd8
`define PCS_ISDN_SYNC_RISES 2'd2
`define PCS_GUARD_SYNCS     2'd2
`define PCS_PD_EDGES        16'd1024

`endif

// ==== core/pcs_serial_port.v ====
`timescale 1ns/100ps
`include "pcs_port_regs.vh"

module pcs_serial_port #(
    parameter [15:0] PD_EDGES = `PCS_PD_EDGES
) (
    input  wire        clock,
    input  wire        nrst,
    input  wire        transmit_frame_sync,
    input  wire        transmit_bit_clock,
    input  wire        receive_frame_sync,
    input  wire        receive_bit_clock,
    input  wire        receive_pcm_in,
    input  wire        master_clock,
    input  wire        power_down_input_n,
    input  wire        companding_law_select,
    output reg         transmit_pcm_out,
    output reg         transmit_pcm_oe_n,
    output reg  [7:0]  rx_word,
    output reg         rx_word_strobe,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr
);

    localparam [3:0] MODE_LONG  = 4'h1;
    localparam [3:0] MODE_SHORT = 4'h2;
    localparam [3:0] MODE_LKA   = 4'h4;
    localparam [3:0] MODE_GCI   = 4'h8;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function [7:0] law_code;
        input [1:0] src;
        input       mu;
        begin
            if (src == `PCS_SRC_ZERO) begin
                law_code = mu ? `PCS_MU_POS_ZERO : `PCS_A_POS_ZERO;
            end else begin
                law_code = mu ? `PCS_MU_POS_FULL : `PCS_A_POS_FULL;
            end
        end
    endfunction

    function [7:0] mw_code;
        input [2:0] ph;
        input       mu;
        reg         inner;
        begin
            inner = ph[1] ^ ph[0];
            if (mu) begin
                mw_code = {ph[2], inner ? `PCS_MU_MW_INNER : `PCS_MU_MW_OUTER};
            end else begin
                mw_code = {ph[2], inner ? `PCS_A_MW_INNER : `PCS_A_MW_OUTER};
            end
        end
    endfunction

    function [4:0] ratio_of;
        input [9:0] n;
        begin
            if (n >= 10'd448) begin
                ratio_of = 5'd16;
            end else if (n >= 10'd288) begin
                ratio_of = 5'd10;
            end else if (n >= 10'd224) begin
                ratio_of = 5'd8;
            end else if (n >= 10'd128) begin
                ratio_of = 5'd6;
            end else if (n >= 10'd48) begin
                ratio_of = 5'd2;
            end else begin
                ratio_of = 5'd1;
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Pin edge detection
    // ------------------------------------------------------------
    reg tfs_p_q, bt_p_q, br_p_q, mc_p_q, rand_p_q;
    wire rx_and   = receive_frame_sync & receive_bit_clock;
    wire tfs_rise = transmit_frame_sync & ~tfs_p_q;
    wire bt_rise  = transmit_bit_clock & ~bt_p_q;
    wire bt_fall  = ~transmit_bit_clock & bt_p_q;
    wire br_rise  = receive_bit_clock & ~br_p_q;
    wire br_fall  = ~receive_bit_clock & br_p_q;
    wire br_edge  = receive_bit_clock ^ br_p_q;
    wire mc_rise  = master_clock & ~mc_p_q;

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tfs_p_q  <= 1'b0;
            bt_p_q   <= 1'b0;
            br_p_q   <= 1'b0;
            mc_p_q   <= 1'b0;
            rand_p_q <= 1'b0;
        end else begin
            tfs_p_q  <= transmit_frame_sync;
            bt_p_q   <= transmit_bit_clock;
            br_p_q   <= receive_bit_clock;
            mc_p_q   <= master_clock;
            rand_p_q <= rx_and;
        end
    end

    // ------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------
    // A static receive clock over three transmit sync rises moves the pins into
    // an ISDN mode; any receive clock edge returns to frame sync timing.
    reg [1:0] still_cnt_q;
    reg       lka_q, gci_q, long_q;
    reg [1:0] fs_hi_q;
    wire      isdn = lka_q | gci_q;
    wire      b2   = receive_frame_sync;

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            still_cnt_q <= 2'd0;
            lka_q       <= 1'b0;
            gci_q       <= 1'b0;
        end else if (br_edge) begin
            still_cnt_q <= 2'd0;
            lka_q       <= 1'b0;
            gci_q       <= 1'b0;
        end else if (tfs_rise) begin
            if (still_cnt_q != `PCS_ISDN_SYNC_RISES) begin
                still_cnt_q <= still_cnt_q + 2'd1;
            end else begin
                lka_q <= receive_bit_clock;
                gci_q <= ~receive_bit_clock;
            end
        end
    end

    // Sync width is judged per frame and steers the next frame on both paths.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fs_hi_q <= 2'd0;
            long_q  <= 1'b0;
        end else if (bt_fall) begin
            if (transmit_frame_sync) begin
                fs_hi_q <= (fs_hi_q == 2'd2) ? 2'd2 : fs_hi_q + 2'd1;
            end else if (fs_hi_q != 2'd0) begin
                long_q  <= (fs_hi_q == 2'd2);
                fs_hi_q <= 2'd0;
            end
        end
    end

    wire [3:0] mode = lka_q ? MODE_LKA : gci_q ? MODE_GCI : long_q ? MODE_LONG : MODE_SHORT;

    // ------------------------------------------------------------
    // Power control
    // ------------------------------------------------------------
    reg        pwr_up_q, mc_seen_q;
    reg [1:0]  guard_q;
    reg [15:0] low_cnt_q;

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pwr_up_q  <= 1'b1;
            guard_q   <= 2'd0;
            low_cnt_q <= 16'd0;
            mc_seen_q <= 1'b0;
        end else begin
            if (mc_rise) begin
                mc_seen_q <= 1'b1;
            end else if (bt_rise) begin
                mc_seen_q <= 1'b0;
            end
            if (transmit_frame_sync | receive_frame_sync) begin
                low_cnt_q <= 16'd0;
            end else if (bt_rise && mc_seen_q && low_cnt_q != PD_EDGES) begin
                low_cnt_q <= low_cnt_q + 16'd1;
            end
            if (!power_down_input_n) begin
                pwr_up_q <= 1'b0;
            end else if (low_cnt_q == PD_EDGES) begin
                pwr_up_q <= 1'b0;
            end else if (!pwr_up_q && tfs_rise && bt_p_q != transmit_bit_clock) begin
                pwr_up_q <= 1'b1;
            end else if (!pwr_up_q && tfs_rise && mc_seen_q) begin
                pwr_up_q <= 1'b1;
            end
            if (!pwr_up_q) begin
                guard_q <= 2'd0;
            end else if (tfs_rise && guard_q != `PCS_GUARD_SYNCS) begin
                guard_q <= guard_q + 2'd1;
            end
        end
    end

    // ------------------------------------------------------------
    // Master clock prescaler
    // ------------------------------------------------------------
    reg [9:0] mc_cnt_q;
    reg [4:0] ratio_q, seq_cnt_q;
    reg [7:0] ticks_q, ticks_frame_q;

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mc_cnt_q      <= 10'd0;
            ratio_q       <= 5'd1;
            seq_cnt_q     <= 5'd0;
            ticks_q       <= 8'd0;
            ticks_frame_q <= 8'd0;
        end else if (tfs_rise) begin
            ratio_q       <= ratio_of(mc_cnt_q);
            mc_cnt_q      <= 10'd0;
            seq_cnt_q     <= 5'd0;
            ticks_frame_q <= ticks_q;
            ticks_q       <= 8'd0;
        end else if (mc_rise && pwr_up_q) begin
            if (mc_cnt_q != 10'h3FF) begin
                mc_cnt_q <= mc_cnt_q + 10'd1;
            end
            if (seq_cnt_q + 5'd1 >= ratio_q) begin
                seq_cnt_q <= 5'd0;
                ticks_q   <= ticks_q + 8'd1;
            end else begin
                seq_cnt_q <= seq_cnt_q + 5'd1;
            end
        end
    end

    // ------------------------------------------------------------
    // Transmit slot engine
    // ------------------------------------------------------------
    reg  [1:0] src_q;
    reg  [7:0] tx_reg_q, tx_sh_q;
    reg  [2:0] mw_ph_q;
    reg  [5:0] k_q;
    reg        tx_act_q, arm_q, started_q, lsb_done_q, drv_ok_q;
    wire [5:0] off  = !b2 ? 6'd0 : lka_q ? `PCS_LKA_B2_OFS : gci_q ? `PCS_GCI_B2_OFS : 6'd0;
    wire [5:0] span = gci_q ? (`PCS_WORD_BITS << 1) : `PCS_WORD_BITS;
    wire [5:0] k_nx = k_q + 6'd1;
    wire [5:0] rel  = k_nx - 6'd1 - off;
    wire [5:0] relc = k_q - 6'd1 - off;
    wire       in_slot_nx = (k_nx > off) && (rel < span);
    wire       in_slot    = (k_q > off) && (relc < span);
    wire       tx_start   = !tx_act_q && pwr_up_q &&
                            ((long_q || gci_q) && !isdn ? (transmit_frame_sync & transmit_bit_clock & !started_q) :
                             gci_q ? (transmit_frame_sync & transmit_bit_clock & !started_q) :
                             (arm_q & bt_rise));
    // The law pin only picks code points; the slot timing below ignores it.
    wire [7:0] tx_src = (src_q == `PCS_SRC_REG) ? tx_reg_q :
                        (src_q == `PCS_SRC_MW)  ? mw_code(mw_ph_q, companding_law_select) :
                        law_code(src_q, companding_law_select);

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tx_act_q          <= 1'b0;
            arm_q             <= 1'b0;
            started_q         <= 1'b0;
            lsb_done_q        <= 1'b0;
            drv_ok_q          <= 1'b0;
            k_q               <= 6'd0;
            tx_sh_q           <= 8'h00;
            mw_ph_q           <= 3'd0;
            transmit_pcm_out  <= 1'b0;
            transmit_pcm_oe_n <= 1'b1;
        end else if (!pwr_up_q) begin
            tx_act_q          <= 1'b0;
            arm_q             <= 1'b0;
            transmit_pcm_oe_n <= 1'b1;
        end else begin
            if (!transmit_frame_sync) begin
                started_q <= 1'b0;
            end
            if (bt_fall) begin
                arm_q <= transmit_frame_sync & !tx_act_q;
            end
            if (tx_start) begin
                tx_act_q   <= 1'b1;
                started_q  <= 1'b1;
                arm_q      <= 1'b0;
                lsb_done_q <= 1'b0;
                drv_ok_q   <= (guard_q == `PCS_GUARD_SYNCS);
                k_q        <= 6'd1;
                if (src_q == `PCS_SRC_MW) begin
                    mw_ph_q <= mw_ph_q + 3'd1;
                end
                if (off == 6'd0) begin
                    tx_sh_q           <= {tx_src[6:0], 1'b0};
                    transmit_pcm_out  <= tx_src[7];
                    transmit_pcm_oe_n <= ~(guard_q == `PCS_GUARD_SYNCS);
                end else begin
                    tx_sh_q <= tx_src;
                end
            end else if (tx_act_q) begin
                if (bt_rise && k_q != 6'h3F) begin
                    k_q <= k_nx;
                    if (in_slot_nx && (!gci_q || !rel[0])) begin
                        transmit_pcm_out  <= tx_sh_q[7];
                        tx_sh_q           <= {tx_sh_q[6:0], 1'b0};
                        transmit_pcm_oe_n <= ~drv_ok_q;
                    end
                end
                if (bt_fall && k_q == off + span) begin
                    lsb_done_q <= 1'b1;
                end
                // Long sync holds the line until the later of LSB middle and sync low.
                if (lsb_done_q && (!long_q || isdn || !transmit_frame_sync)) begin
                    tx_act_q          <= 1'b0;
                    transmit_pcm_oe_n <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------
    // Frame sync modes time the receive side from the receive pins, with no assumed phase to
    // the transmit side (only long/short comes from transmit sync); ISDN modes reuse the transmit slot counter.
    reg  [7:0] rx_sh_q;
    reg  [3:0] rx_cnt_q;
    reg        rx_run_q, rx_rearm_q, rx_new_q;
    wire       rd_rx;

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rx_sh_q        <= 8'h00;
            rx_cnt_q       <= 4'd0;
            rx_run_q       <= 1'b0;
            rx_rearm_q     <= 1'b1;
            rx_word        <= 8'h00;
            rx_word_strobe <= 1'b0;
            rx_new_q       <= 1'b0;
        end else begin
            rx_word_strobe <= 1'b0;
            if (!receive_frame_sync) begin
                rx_rearm_q <= 1'b1;
            end
            if (!pwr_up_q) begin
                rx_run_q <= 1'b0;
                rx_cnt_q <= 4'd0;
            end else if (isdn) begin
                if (bt_fall && tx_act_q && in_slot && (!gci_q || relc[0])) begin
                    rx_sh_q  <= {rx_sh_q[6:0], receive_pcm_in};
                    rx_cnt_q <= rx_cnt_q + 4'd1;
                    if (rx_cnt_q == 4'd7) begin
                        rx_word        <= {rx_sh_q[6:0], receive_pcm_in};
                        rx_word_strobe <= 1'b1;
                    end
                end else if (tx_start) begin
                    rx_cnt_q <= 4'd0;
                end
            end else if (!rx_run_q) begin
                if (long_q && rx_and && !rand_p_q && rx_rearm_q) begin
                    rx_run_q   <= 1'b1;
                    rx_rearm_q <= 1'b0;
                    rx_cnt_q   <= 4'd0;
                end else if (!long_q && br_fall && receive_frame_sync && rx_rearm_q) begin
                    rx_run_q   <= 1'b1;
                    rx_rearm_q <= 1'b0;
                    rx_cnt_q   <= 4'd0;
                end
            end else begin
                if (br_fall && rx_cnt_q != 4'd8) begin
                    rx_sh_q  <= {rx_sh_q[6:0], receive_pcm_in};
                    rx_cnt_q <= rx_cnt_q + 4'd1;
                end
                if (br_rise && rx_cnt_q == 4'd8) begin
                    rx_word        <= rx_sh_q;
                    rx_word_strobe <= 1'b1;
                    rx_run_q       <= 1'b0;
                end
            end
            if (rx_word_strobe) begin
                rx_new_q <= 1'b1;
            end else if (rd_rx) begin
                rx_new_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // One wait state: pready rises at the end of the first access cycle, so writes land
    // and read data is sampled at the second access edge.
    wire acc  = psel & penable & pready;
    assign rd_rx = acc & ~pwrite & (paddr == `PCS_RXWORD_OFS);

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            src_q    <= `PCS_CTRL_RST;
            tx_reg_q <= `PCS_TXWORD_RST;
            prdata   <= 32'h0000_0000;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && penable && !pready) begin
                if (paddr == `PCS_CTRL_OFS) begin
                    prdata <= {30'h0, src_q};
                end else if (paddr == `PCS_TXWORD_OFS) begin
                    prdata <= {24'h0, tx_reg_q};
                end else if (paddr == `PCS_RXWORD_OFS) begin
                    prdata <= {24'h0, rx_word};
                end else if (paddr == `PCS_STATUS_OFS) begin
                    prdata <= {24'h0, companding_law_select, rx_new_q,
                               guard_q == `PCS_GUARD_SYNCS, pwr_up_q, mode};
                end else if (paddr == `PCS_PRESCALE_OFS) begin
                    prdata <= {16'h0, ticks_frame_q, 3'h0, ratio_q};
                end else begin
                    pslverr <= 1'b1;
                end
            end
            if (acc && pwrite) begin
                if (paddr == `PCS_CTRL_OFS) begin
                    src_q <= pwdata[`PCS_CTRL_SRC_MSB:`PCS_CTRL_SRC_LSB];
                end else if (paddr == `PCS_TXWORD_OFS) begin
                    tx_reg_q <= pwdata[7:0];
                end
            end
        end
    end

endmodule // pcs_serial_port

// ==== tb/pcs_highway_model.sv ====
`timescale 1ns/100ps
module pcs_highway_model (
    input wire        clock,
    input wire        long_sync,
    input wire        quiet,
    input wire [7:0]  rx_data,
    input wire        transmit_pcm_out,
    input wire        transmit_pcm_oe_n,
    output wire       bit_clock,
    output wire       frame_sync,
    output reg        pcm_to_dut = 1'b0,
    output wire       frame_start,
    output reg        word_seen = 1'b0,
    output reg [7:0]  word_q = 8'h00
);
    // ------------------------------------------------
    // Free-running highway, 16 bits a frame
    // ------------------------------------------------
    logic [4:0] ph = 5'h00;
    logic [3:0] bit_n = 4'h0;
    logic [7:0] shift_q = 8'h00;
    logic [3:0] cnt_q = 4'h0;
    // 32 cycles a bit keeps the rate under 4096 kHz and the clock always toggling.
    assign bit_clock = !ph[4];
    assign frame_sync = !quiet && (long_sync ? bit_n < 4'h2 : bit_n == 4'hF);
    assign frame_start = bit_n == 4'h0 && ph == 5'h00;
    always @(posedge clock) begin
        ph <= ph + 5'h01;
        word_seen <= 1'b0;
        if (ph == 5'h1F) begin
            bit_n <= bit_n + 4'h1;
            if (bit_n == 4'hF) shift_q <= rx_data;
            // Outside the slot the line toggles, so a stale bit is never taken for data.
            pcm_to_dut <= bit_n == 4'hF ? rx_data[7] : bit_n < 4'h7 ? shift_q[3'h6 - bit_n[2:0]] : ~pcm_to_dut;
        end
        if (ph == 5'h0F && transmit_pcm_oe_n === 1'b0) begin
            word_q <= {word_q[6:0], transmit_pcm_out};
            cnt_q <= cnt_q + 4'h1;
        end else if (transmit_pcm_oe_n && cnt_q != 4'h0) begin
            word_seen <= 1'b1;
            cnt_q <= 4'h0;
        end
    end
endmodule // pcs_highway_model

// ==== tb/pcs_serial_port_checker.sv ====
`timescale 1ns/100ps
module pcs_serial_port_checker #(
    parameter [15:0] PD_EDGES = 16'h0400
) (
    input wire       clock,
    input wire       nrst,
    input wire       power_down_input_n,
    input wire       transmit_pcm_oe_n,
    input wire [7:0] rx_word,
    input wire       rx_word_strobe,
    input wire       psel,
    input wire       penable,
    input wire [7:0] paddr,
    input wire       pready,
    input wire       pslverr
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    // ------------------------------------------------
    // Port rules
    // ------------------------------------------------
    // Four cycles let the pin pass through pwr_up_q and the output register first.
    sequence s_pd;
        !power_down_input_n [*4];
    endsequence
    sequence s_acc;
        psel && penable && !pready;
    endsequence
    chk_pd_out_off: assert property (s_pd |-> transmit_pcm_oe_n)
        else $error("output driven while powered down");
    chk_pd_no_rx: assert property (s_pd |-> !rx_word_strobe)
        else $error("word received while powered down");
    chk_wake_first: assert property ($fell(transmit_pcm_oe_n) |-> $past(power_down_input_n, 3))
        else $error("output driven straight out of power down");
    chk_strobe_one: assert property (rx_word_strobe |=> !rx_word_strobe)
        else $error("receive strobe longer than one cycle");
    chk_word_hold: assert property ($changed(rx_word) |-> rx_word_strobe)
        else $error("received word changed without strobe");
    chk_apb_wait: assert property (s_acc |=> pready)
        else $error("ready not one cycle after access");
    chk_ready_one: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    chk_bad_addr: assert property (pready && paddr > 8'h10 |-> pslverr)
        else $error("unmapped address not refused");
endmodule // pcs_serial_port_checker

// ==== tb/pcs_serial_port_tb.sv ====
`timescale 1ns/100ps
module pcs_serial_port_tb;
    logic clock = 1'b0, nrst = 1'b0, pdn = 1'b1, law = 1'b1, long_sync = 1'b0, quiet = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] rxd = 8'h00, paddr = 8'h00, v, e;
    logic [31:0] pwdata = 32'h0;
    wire bclk, fsync, pin, fbeg, seen, out, oe_n, stb, pready, pslverr;
    wire [7:0] txw, rxw;
    wire [31:0] prdata;
    int seed = 38, num_errors = 0, checked = 0, i, k, n_seen = 0;
    logic [32:0] rq[$], mq[$];
    logic [7:0] tq[$], xq[$];
    always #5 clock = ~clock;
    pcs_serial_port #(.PD_EDGES(16'h0010)) dut (.clock(clock), .nrst(nrst),
        .transmit_frame_sync(fsync), .transmit_bit_clock(bclk), .receive_frame_sync(fsync),
        .receive_bit_clock(bclk), .receive_pcm_in(pin), .master_clock(bclk), .power_down_input_n(pdn),
        .companding_law_select(law), .transmit_pcm_out(out), .transmit_pcm_oe_n(oe_n), .rx_word(rxw),
        .rx_word_strobe(stb), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    pcs_highway_model far (.clock(clock), .long_sync(long_sync), .quiet(quiet), .rx_data(rxd),
        .transmit_pcm_out(out), .transmit_pcm_oe_n(oe_n), .bit_clock(bclk), .frame_sync(fsync),
        .pcm_to_dut(pin), .frame_start(fbeg), .word_seen(seen), .word_q(txw));
    task conclude;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task bad;
        num_errors++;
        conclude;
    endtask
    task cmp_reg(input logic [32:0] x, input logic [32:0] g);
        checked++;
        if (g !== x) begin
            num_errors++;
            $display("BAD %0t exp %h got %h", $time, x, g);
        end
    endtask
    task cmp_word(input logic [7:0] x, input logic [7:0] g);
        cmp_reg({25'h0, x}, {25'h0, g});
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) bad;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task rd(input logic [7:0] a, input logic [32:0] x, input logic [32:0] m);
        rq.push_back(x & m);
        mq.push_back(m);
        apb(1'b0, a, 32'h0);
    endtask
    task frames(input int cnt);
        int n;
        repeat (cnt) begin
            n = 0;
            do begin
                @(posedge clock);
                n++;
            end while (fbeg !== 1'b1 && n < 600);
            if (n >= 600) bad;
        end
    endtask
    // Expectations are queued only once two whole frames have passed with the new setting.
    task run(input logic [7:0] tx, input logic [7:0] rx);
        rxd <= rx;
        frames(3);
        tq.push_back(tx);
        xq.push_back(rx);
        frames(2);
        if (tq.size() != 0 || xq.size() != 0) bad;
    endtask
    always @(posedge clock) begin
        if (psel && penable && pready && !pwrite && rq.size() != 0)
            cmp_reg(rq.pop_front(), {pslverr, prdata} & mq.pop_front());
        if (seen) n_seen++;
        if (seen && tq.size() != 0) cmp_word(tq.pop_front(), txw);
        if (stb && xq.size() != 0) cmp_word(xq.pop_front(), rxw);
    end
    initial begin
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        rd(8'h00, 33'h0, 33'h1_0000_0003);
        rd(8'h04, 33'hFF, 33'h1_0000_00FF);
        rd(8'h14, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
        for (i = 0; i < 16; i++) begin
            v = $random(seed);
            law <= i[0];
            long_sync <= i[1];
            apb(1'b1, 8'h04, {24'h0, v});
            apb(1'b1, 8'h00, i / 4);
            // The milliwatt sequence steps one word a frame from its first word; a run spans five frames.
            k = (5 * i + 6) % 8;
            e = i < 4 ? v : i < 8 ? {k[2], (k[1] ^ k[0]) ? (i[0] ? 7'h0B : 7'h21) : (i[0] ? 7'h1E : 7'h34)} :
                i < 12 ? (i[0] ? 8'hFF : 8'hD5) : (i[0] ? 8'h80 : 8'hAA);
            run(e, $random(seed));
        end
        for (i = 0; i < 2; i++) begin
            if (i == 0) pdn <= 1'b0;
            else quiet <= 1'b1;
            frames(2);
            rd(8'h0C, 33'h0, 33'h1_0000_0010);
            pdn <= 1'b1;
            quiet <= 1'b0;
            k = n_seen;
            frames(3);
            cmp_word(k[7:0], n_seen[7:0]);
            run(8'h80, $random(seed));
        end
        conclude;
    end
endmodule // pcs_serial_port_tb
bind pcs_serial_port pcs_serial_port_checker #(.PD_EDGES(PD_EDGES)) chk (.clock(clock), .nrst(nrst),
    .power_down_input_n(power_down_input_n), .transmit_pcm_oe_n(transmit_pcm_oe_n), .rx_word(rx_word),
    .rx_word_strobe(rx_word_strobe), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
    .pslverr(pslverr));
